/* cpd_map.svh */
// Summary of operation
// - txd high or open: both drivers off
// - txd low while normal: both drivers on, bus dominant
// - dominant too long: drivers cut off
// - rxd is push-pull while normal
// - rxd high recessive, low dominant
// - low-power-off: rxd left floating
// - low-power-off: drivers off, bus left recessive
// - debug mode forces transceiver normal operation unless low-power-off is set
`ifndef CPD_MAP_SVH
`define CPD_MAP_SVH

`define CPD_CLK_MHZ         100
`define CPD_DOM_TIMEOUT_US  1000
`define CPD_RX_FIFO_DEPTH   16
`define CPD_RX_FIFO_WIDTH   1
`define CPD_RXD_IDLE        1'b1
`define CPD_TXD_RECESSIVE   1'b1

`endif

/* cpd_pkg.sv */
`default_nettype none
package cpd_pkg;

  typedef enum logic [1:0] {
    CPD_MODE_OFF,
    CPD_MODE_LOW_PWR,
    CPD_MODE_NORMAL
  } cpd_mode_t;

  typedef struct packed {
    logic drv_on;
    logic rxd;
    logic rxd_oe;
    logic lock;
  } cpd_top_st_t;

endpackage
`default_nettype wire

/* cpd_tmr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cpd_tmr_if;
  logic run;
  logic expired;

  modport ctrl (
    output run,
    input  expired
  );

  modport tmr (
    input  run,
    output expired
  );
endinterface
`default_nettype wire

/* cpd_dom_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module cpd_dom_timer #(
  parameter int LIMIT = 100000
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  cpd_tmr_if.tmr    tif
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM_M1 = CW'(LIMIT - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          expired;
  } cpd_tmr_st_t;

  cpd_tmr_st_t s;
  cpd_tmr_st_t next_s;

  always_comb begin
    next_s = s;
    if (!tif.run) begin
      next_s.cnt     = '0;
      next_s.expired = 1'b0;
    end else if (s.cnt >= LIM_M1) begin
      next_s.expired = 1'b1;
    end else begin
      next_s.cnt = s.cnt + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tif.expired = s.expired;

  a_timer_limit: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s.expired) |-> $past(s.cnt) == LIM_M1)
    else $error("timeout fired at wrong count");

  a_timer_clear: assert property (@(posedge sys_clk) disable iff (rst)
    !tif.run |=> !s.expired && s.cnt == '0)
    else $error("timer not cleared by recessive txd");
endmodule
`default_nettype wire

/* cpd_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module cpd_fifo #(
  parameter int W = 1,
  parameter int D = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         clear,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         full;
  logic         empty;
  logic         do_wr;
  logic         do_rd;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign do_wr     = in_valid && !full;
  assign do_rd     = out_ready && !empty;

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // clear drops stale samples so a wake never replays old bus levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule
`default_nettype wire

/* cpd_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cpd_map.svh"
module cpd_top #(
  parameter int DOM_TIMEOUT_CYC = `CPD_DOM_TIMEOUT_US * `CPD_CLK_MHZ,
  parameter int RX_FIFO_DEPTH   = `CPD_RX_FIFO_DEPTH,
  parameter int RX_FIFO_WIDTH   = `CPD_RX_FIFO_WIDTH
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic txd,
  input  wire logic normal_mode,
  input  wire logic low_power_off_mode,
  input  wire logic debug_mode,
  input  wire logic bus_dominant_sensed,
  output logic      canh_drive_en,
  output logic      canl_drive_en,
  output logic      rxd_out,
  output logic      rxd_oe,
  output logic      tx_timeout_lock
);

  // low-power-off outranks everything, debug then forces normal
  function automatic cpd_pkg::cpd_mode_t decode_mode(
    input logic low_pwr,
    input logic normal,
    input logic debug
  );
    cpd_pkg::cpd_mode_t m;
    m = cpd_pkg::CPD_MODE_OFF;
    if (low_pwr) begin
      m = cpd_pkg::CPD_MODE_LOW_PWR;
    end else if (normal || debug) begin
      m = cpd_pkg::CPD_MODE_NORMAL;
    end
    return m;
  endfunction

  cpd_pkg::cpd_mode_t  mode;
  cpd_pkg::cpd_top_st_t s;
  cpd_pkg::cpd_top_st_t next_s;
  logic                 active;
  logic                 txd_dominant;
  logic                 next_lock;
  logic                 fifo_in_ready;
  logic                 fifo_out_valid;
  logic [RX_FIFO_WIDTH-1:0] fifo_out_data;
  logic [RX_FIFO_WIDTH-1:0] fifo_in_data;

  cpd_tmr_if tif ();

  assign mode         = decode_mode(low_power_off_mode, normal_mode, debug_mode);
  assign active       = (mode == cpd_pkg::CPD_MODE_NORMAL);
  assign txd_dominant = (txd != `CPD_TXD_RECESSIVE);
  assign tif.run      = active && txd_dominant;
  assign fifo_in_data = RX_FIFO_WIDTH'(!bus_dominant_sensed);

  cpd_dom_timer #(
    .LIMIT (DOM_TIMEOUT_CYC)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tif     (tif)
  );

  // sampler holds off while the queue is full, so that cycle's bus level is dropped
  cpd_fifo #(
    .W (RX_FIFO_WIDTH),
    .D (RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clear     (!active),
    .in_valid  (active && fifo_in_ready),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (active),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    next_s = s;
    // a fresh expiry wins over the release by txd going high
    next_lock = tif.expired || (s.lock && txd_dominant);
    next_s.lock = next_lock;
    case (mode)
      cpd_pkg::CPD_MODE_NORMAL: begin
        next_s.drv_on = txd_dominant && !next_lock;
        next_s.rxd_oe = 1'b1;
        if (fifo_out_valid) begin
          next_s.rxd = fifo_out_data[0];
        end
      end
      cpd_pkg::CPD_MODE_LOW_PWR: begin
        next_s.drv_on = 1'b0;
        next_s.rxd_oe = 1'b0;
        next_s.rxd    = `CPD_RXD_IDLE;
        next_s.lock   = 1'b0;
      end
      default: begin
        // outside normal the bus stays recessive and rxd parks high
        next_s.drv_on = 1'b0;
        next_s.rxd_oe = 1'b0;
        next_s.rxd    = `CPD_RXD_IDLE;
        next_s.lock   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s <= '{drv_on: 1'b0, rxd: `CPD_RXD_IDLE, rxd_oe: 1'b0, lock: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // both drivers share one flop: they must never split on the bus
  assign canh_drive_en   = s.drv_on;
  assign canl_drive_en   = s.drv_on;
  assign rxd_out         = s.rxd;
  assign rxd_oe          = s.rxd_oe;
  assign tx_timeout_lock = s.lock;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_normal_recessive;
    active && !txd_dominant;
  endsequence

  sequence s_normal_dominant_ok;
    active && txd_dominant && !s.lock && !tif.expired;
  endsequence

  sequence s_steady_dominant_bus;
    (active && bus_dominant_sensed)[*6];
  endsequence

  sequence s_steady_recessive_bus;
    (active && !bus_dominant_sensed)[*6];
  endsequence

  a_recessive_off: assert property (
    s_normal_recessive |=> !canh_drive_en && !canl_drive_en)
    else $error("drivers on while txd recessive");

  a_dominant_on: assert property (
    s_normal_dominant_ok |=> canh_drive_en && canl_drive_en)
    else $error("drivers off while txd dominant");

  a_timeout_cut: assert property (
    tif.expired && active |=> !canh_drive_en && tx_timeout_lock)
    else $error("drivers stayed on after dominant timeout");

  a_rxd_push_pull: assert property (
    active |=> rxd_oe)
    else $error("rxd not driven in normal mode");

  a_rxd_low_dom: assert property (
    s_steady_dominant_bus |-> !rxd_out)
    else $error("rxd high on dominant bus");

  a_rxd_high_rec: assert property (
    s_steady_recessive_bus |-> rxd_out)
    else $error("rxd low on recessive bus");

  a_sleep_rxd_float: assert property (
    low_power_off_mode |=> !rxd_oe)
    else $error("rxd driven in low-power-off");

  a_sleep_drv_off: assert property (
    low_power_off_mode |=> !canh_drive_en && !canl_drive_en)
    else $error("drivers on in low-power-off");

  a_debug_normal: assert property (
    debug_mode && !low_power_off_mode |=> rxd_oe)
    else $error("debug mode did not enter normal");

  a_lock_hold: assert property (
    tx_timeout_lock && txd_dominant && active |=> tx_timeout_lock && !canh_drive_en)
    else $error("lock released while txd still dominant");

  a_lock_release: assert property (
    tx_timeout_lock && !txd_dominant && !tif.expired |=> !tx_timeout_lock)
    else $error("lock kept after txd went recessive");

  // rx path runs push then pop, so each bus sample lands two edges later
  sequence s_dom_sample;
    (active && bus_dominant_sensed) ##1 active;
  endsequence

  sequence s_rec_sample;
    (active && !bus_dominant_sensed) ##1 active;
  endsequence

  sequence s_lock_released;
    (active && tx_timeout_lock && !txd_dominant) ##1 (active && !txd_dominant);
  endsequence

  sequence s_resume_dominant;
    active && txd_dominant;
  endsequence

  a_rxd_lat_dom: assert property (
    s_dom_sample |=> !rxd_out)
    else $error("dominant bus sample not on rxd");

  a_rxd_lat_rec: assert property (
    s_rec_sample |=> rxd_out)
    else $error("recessive bus sample not on rxd");

  // a full queue would stall sampling and skip bus levels
  a_fifo_pace: assert property (
    active |-> fifo_in_ready)
    else $error("rx queue filled while draining");

  a_rxd_hold: assert property (
    active && !fifo_out_valid |=> $stable(rxd_out))
    else $error("rxd changed with no new sample");

  a_rxd_oe_rise: assert property (
    $rose(rxd_oe) |-> $past(active))
    else $error("rxd enabled outside normal");

  a_rxd_oe_fall: assert property (
    $fell(rxd_oe) |-> $past(!active))
    else $error("rxd released while normal");

  a_rxd_float_park: assert property (
    !rxd_oe |-> rxd_out)
    else $error("rxd level not parked while floating");

  a_idle_drv_off: assert property (
    !active |=> !canh_drive_en && !canl_drive_en)
    else $error("drivers on outside normal");

  a_idle_rxd_park: assert property (
    !active |=> rxd_out && !rxd_oe)
    else $error("rxd not parked outside normal");

  a_idle_lock_clear: assert property (
    !active |=> !tx_timeout_lock)
    else $error("lock kept outside normal");

  a_sleep_over_debug: assert property (
    low_power_off_mode && debug_mode |=> !canh_drive_en && !rxd_oe)
    else $error("debug mode overrode low-power-off");

  a_neither_quiet: assert property (
    !low_power_off_mode && !normal_mode && !debug_mode |=> !canh_drive_en && !rxd_oe)
    else $error("bus or rxd driven with no mode set");

  a_drv_need_dom: assert property (
    !txd_dominant |=> !canh_drive_en && !canl_drive_en)
    else $error("drivers on after recessive txd");

  a_drv_rise_src: assert property (
    $rose(canh_drive_en) |-> $past(active && txd_dominant))
    else $error("drivers rose without dominant txd");

  a_lock_drv_off: assert property (
    tx_timeout_lock |-> !canh_drive_en && !canl_drive_en)
    else $error("drivers on while locked");

  a_expiry_src: assert property (
    tif.expired |-> $past(tif.run))
    else $error("timer expired without dominant txd");

  a_timer_idle: assert property (
    !active |=> !tif.expired)
    else $error("timer kept running outside normal");

  a_lock_rise_src: assert property (
    $rose(tx_timeout_lock) |-> $past(tif.expired))
    else $error("lock set without timer expiry");

  a_lock_fall_src: assert property (
    $fell(tx_timeout_lock) |-> $past(!txd_dominant || !active))
    else $error("lock cleared while txd dominant");

  // one recessive sample after expiry is not enough; two free the drivers
  a_resume_after_release: assert property (
    s_lock_released ##1 s_resume_dominant |=> canh_drive_en && canl_drive_en)
    else $error("transmit not resumed after release");

  a_debug_drive: assert property (
    debug_mode && !low_power_off_mode && txd_dominant && !tx_timeout_lock && !tif.expired
    |=> canh_drive_en)
    else $error("debug mode did not drive the bus");

endmodule
`default_nettype wire

/* cpd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpd_host_model (
  input  wire logic sys_clk,
  input  wire logic tx_bit,
  input  wire logic rxd_out,
  input  wire logic rxd_oe,
  output logic      txd,
  output logic      rxd_pin
);
  logic flip = 1'b0;

  // controller transmit output wired straight to the phy
  assign txd = tx_bit;

  always @(posedge sys_clk) begin
    flip <= ~flip;
  end

  // floating line seen as a changing level, never a stale copy
  assign rxd_pin = rxd_oe ? rxd_out : flip;
endmodule
`default_nettype wire

/* tb_can_phy_digital_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_can_phy_digital_control;
  localparam int LIM = 20;
  logic sys_clk, rst, tx_bit, normal_mode, low_power_off_mode, debug_mode, bus_dom;
  logic txd, canh, canl, rxd_out, rxd_oe, lock, rxd_pin;
  logic [1:0] hist;
  int   num_errors = 0;
  int   check_count = 0;
  int   cyc = 0;

  cpd_top #(.DOM_TIMEOUT_CYC(LIM)) dut (
    .sys_clk(sys_clk), .rst(rst), .txd(txd), .normal_mode(normal_mode),
    .low_power_off_mode(low_power_off_mode), .debug_mode(debug_mode),
    .bus_dominant_sensed(bus_dom), .canh_drive_en(canh), .canl_drive_en(canl),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .tx_timeout_lock(lock)
  );

  cpd_host_model host (
    .sys_clk(sys_clk), .tx_bit(tx_bit), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .txd(txd), .rxd_pin(rxd_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard, well above the few hundred cycles of the tests
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  function automatic logic drv_exp(input logic t, input logic nm, input logic lp,
                                   input logic dbg);
    return !lp && (nm || dbg) && !t;
  endfunction

  initial begin
    rst = 1'b1;
    tx_bit = 1'b1;
    normal_mode = 1'b1;
    low_power_off_mode = 1'b0;
    debug_mode = 1'b0;
    bus_dom = 1'b0;
    hist = 2'b00;
    void'($urandom(71));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int m = 0; m < 8; m++) begin
      for (int t = 0; t < 2; t++) begin
        normal_mode = m[0];
        low_power_off_mode = m[1];
        debug_mode = m[2];
        tx_bit = t[0];
        step(2);
        chk(canh, drv_exp(t[0], m[0], m[1], m[2]), "canh by mode");
        chk(canl, drv_exp(t[0], m[0], m[1], m[2]), "canl by mode");
        chk(rxd_oe, !m[1] && (m[0] || m[2]), "rxd enable by mode");
      end
    end
    $display("test modes done");
    normal_mode = 1'b1;
    low_power_off_mode = 1'b0;
    debug_mode = 1'b0;
    tx_bit = 1'b1;
    step(3);
    for (int i = 0; i < 200; i++) begin
      bus_dom = 1'($urandom_range(1, 0));
      // periodic recessive keeps random runs short of the timeout
      tx_bit = (i % 8 == 7) ? 1'b1 : 1'($urandom_range(1, 0));
      hist = {hist[0], bus_dom};
      step(1);
      chk(canh, !tx_bit, "canh follows txd");
      chk(rxd_pin, !hist[1], "rxd follows bus");
    end
    $display("test random traffic done");
    tx_bit = 1'b0;
    step(LIM);
    chk(canh, 1'b1, "drivers cut too early");
    step(1);
    chk(canh, 1'b0, "drivers not cut");
    chk(lock, 1'b1, "lock missing");
    step(7);
    chk(canl, 1'b0, "drivers back while dominant");
    tx_bit = 1'b1;
    step(3);
    chk(lock, 1'b0, "lock stuck");
    tx_bit = 1'b0;
    step(1);
    chk(canh, 1'b1, "transmit not re-enabled");
    $display("test timeout done");
    rst = 1'b1;
    step(1);
    chk(canh, 1'b0, "drivers in reset");
    chk(rxd_oe, 1'b0, "rxd enable in reset");
    chk(lock, 1'b0, "lock in reset");
    rst = 1'b0;
    tx_bit = 1'b1;
    step(2);
    chk(rxd_oe, 1'b1, "rxd enable after reset");
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
